//--- src/adc_input_mux_select.sv
/*
 Input selection registers and switch decoding for the converter unit.
 Assumes single-cycle register writes and reads from the core, and a
 temperature sensor enable supplied by the reference control register.
*/
`timescale 1ns/1ps

// Functional notes
// RQ1: Positive field 5 bits, reset none, upper zero
// RQ2: Negative field 5 bits, reset none, upper zero
// RQ3: Negative codes: pins, reference, ground single-ended
// RQ4: Port 2 codes only on wide packages
// RQ5: Positive codes: pins, temperature sensor, supply
// RQ6: Sensor powered only while enable bit set
// RQ7: Differential mode unless negative is ground
// RQ8: Single-ended flag and one-hot switch enables
module adc_input_mux_select #(
    parameter bit HAS_PORT2 = 1'b1 // Package brings out port 2 pins
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [7:0] sfr_addr, // Register address
    input wire logic [7:0] sfr_wdata, // Write data
    input wire logic sfr_we, // Write strobe
    input wire logic sfr_re, // Read strobe
    input wire logic temp_sensor_power_on, // Enable from reference control
    output logic [7:0] sfr_rdata, // Registered read data
    output logic [15:0] pos_pin_en, // Positive switch to port 0/1 pins
    output logic [3:0] pos_p2_en, // Positive switch to port 2 pins
    output logic pos_temp_en, // Positive switch to temperature sensor
    output logic pos_vdd_en, // Positive switch to supply
    output logic [15:0] neg_pin_en, // Negative switch to port 0/1 pins
    output logic [3:0] neg_p2_en, // Negative switch to port 2 pins
    output logic neg_vref_en, // Negative switch to reference
    output logic neg_gnd_en, // Negative switch to ground
    output logic single_ended, // Converter single-ended mode
    output logic temp_sensor_pwr // Sensor bias supply enable
);
    logic [4:0] pos_sel;
    logic [4:0] neg_sel;

    function automatic logic [15:0] pin_onehot(input logic [4:0] code);
        pin_onehot = (code <= amux_pkg::CODE_PORT_LAST)
            ? (16'h0001 << code[3:0]) : 16'h0000;
    endfunction

    function automatic logic [3:0] p2_onehot(input logic [4:0] code,
                                             input logic present);
        logic [4:0] idx;
        idx = code - amux_pkg::CODE_P2_FIRST;
        p2_onehot = (present && code >= amux_pkg::CODE_P2_FIRST &&
                     code <= amux_pkg::CODE_P2_LAST)
            ? (4'h1 << idx[1:0]) : 4'h0;
    endfunction

    wire pos_hit = sfr_we && (sfr_addr == amux_pkg::POS_SEL_ADDR);
    wire neg_hit = sfr_we && (sfr_addr == amux_pkg::NEG_SEL_ADDR);
    wire [7:0] next_rdata =
        (sfr_addr == amux_pkg::POS_SEL_ADDR) ? {3'h0, pos_sel} : // [RQ1]
        (sfr_addr == amux_pkg::NEG_SEL_ADDR) ? {3'h0, neg_sel} : // [RQ2]
        8'h00;
    wire [15:0] next_pos_pin = pin_onehot(pos_sel); // [RQ5]
    wire [15:0] next_neg_pin = pin_onehot(neg_sel); // [RQ3]
    wire [3:0] next_pos_p2 = p2_onehot(pos_sel, HAS_PORT2); // [RQ4]
    wire [3:0] next_neg_p2 = p2_onehot(neg_sel, HAS_PORT2); // [RQ4]
    wire next_pos_temp = (pos_sel == amux_pkg::CODE_SPECIAL_A); // [RQ5]
    wire next_pos_vdd = (pos_sel == amux_pkg::CODE_SPECIAL_B); // [RQ5]
    wire next_neg_vref = (neg_sel == amux_pkg::CODE_SPECIAL_A); // [RQ3]
    wire next_neg_gnd = (neg_sel == amux_pkg::CODE_SPECIAL_B); // [RQ3]

    // Upper bits are dropped on write so they always read back zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_sel <= amux_pkg::SEL_RESET;
            neg_sel <= amux_pkg::SEL_RESET;
        end else begin
            if (pos_hit) pos_sel <= sfr_wdata[4:0]; // [RQ1]
            if (neg_hit) neg_sel <= sfr_wdata[4:0]; // [RQ2]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) sfr_rdata <= 8'h00;
        else if (sfr_re) sfr_rdata <= next_rdata;
    end

    // Switch enables are registered so no decode glitch reaches an
    // analog switch; selection changes land one cycle after the write.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_pin_en <= 16'h0000;
            pos_p2_en <= 4'h0;
            pos_temp_en <= 1'b0;
            pos_vdd_en <= 1'b0;
            neg_pin_en <= 16'h0000;
            neg_p2_en <= 4'h0;
            neg_vref_en <= 1'b0;
            neg_gnd_en <= 1'b0;
            single_ended <= 1'b0;
            temp_sensor_pwr <= 1'b0;
        end else begin
            pos_pin_en <= next_pos_pin; // [RQ8]
            pos_p2_en <= next_pos_p2; // [RQ8]
            pos_temp_en <= next_pos_temp; // [RQ8]
            pos_vdd_en <= next_pos_vdd; // [RQ8]
            neg_pin_en <= next_neg_pin; // [RQ8]
            neg_p2_en <= next_neg_p2; // [RQ8]
            neg_vref_en <= next_neg_vref; // [RQ8]
            neg_gnd_en <= next_neg_gnd; // [RQ8]
            single_ended <= next_neg_gnd; // [RQ7] [RQ8]
            temp_sensor_pwr <= temp_sensor_power_on; // [RQ6]
        end
    end

    // Write steps: strobe edge, field edge, then switch edge
    sequence s_neg_write_gnd;
        neg_hit && sfr_wdata[4:0] == amux_pkg::CODE_SPECIAL_B;
    endsequence

    sequence s_neg_write_other;
        neg_hit && sfr_wdata[4:0] != amux_pkg::CODE_SPECIAL_B;
    endsequence

    sequence s_pos_read;
        sfr_re && sfr_addr == amux_pkg::POS_SEL_ADDR;
    endsequence

    sequence s_other_read;
        sfr_re && sfr_addr != amux_pkg::POS_SEL_ADDR &&
        sfr_addr != amux_pkg::NEG_SEL_ADDR;
    endsequence

    a_single_ended_set: assert property ( // [RQ7]
        @(posedge clk) disable iff (!rst_n)
        s_neg_write_gnd |-> ##2 single_ended)
        else $error("single-ended not set after ground select");

    a_single_ended_clr: assert property ( // [RQ7]
        @(posedge clk) disable iff (!rst_n)
        s_neg_write_other |-> ##2 !single_ended)
        else $error("single-ended kept after other select");

    a_diff_mode: assert property ( // [RQ7]
        @(posedge clk) disable iff (!rst_n)
        $past(neg_sel) != amux_pkg::CODE_SPECIAL_B |-> !single_ended)
        else $error("single-ended without ground select");

    a_gnd_flag_match: assert property ( // [RQ8]
        @(posedge clk) disable iff (!rst_n)
        single_ended == neg_gnd_en)
        else $error("single-ended flag and ground switch differ");

    a_pos_upper_zero: assert property ( // [RQ1]
        @(posedge clk) disable iff (!rst_n)
        s_pos_read
        |=> sfr_rdata[7:5] == 3'h0 && sfr_rdata[4:0] == $past(pos_sel))
        else $error("positive select readback wrong");

    a_neg_readback: assert property ( // [RQ2]
        @(posedge clk) disable iff (!rst_n)
        neg_hit ##1 (sfr_re && sfr_addr == amux_pkg::NEG_SEL_ADDR && !neg_hit)
        |=> sfr_rdata == {3'h0, $past(sfr_wdata[4:0], 2)})
        else $error("negative select readback wrong");

    a_unmapped_read: assert property ( // [RQ1]
        @(posedge clk) disable iff (!rst_n)
        s_other_read |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");

    a_rdata_hold: assert property ( // [RQ2]
        @(posedge clk) disable iff (!rst_n)
        !sfr_re |=> $stable(sfr_rdata))
        else $error("read data changed without read");

    a_pos_onehot: assert property ( // [RQ8]
        @(posedge clk) disable iff (!rst_n)
        $onehot0({pos_pin_en, pos_p2_en, pos_temp_en, pos_vdd_en}))
        else $error("positive switches not one-hot");

    a_neg_onehot: assert property ( // [RQ8]
        @(posedge clk) disable iff (!rst_n)
        $onehot0({neg_pin_en, neg_p2_en, neg_vref_en, neg_gnd_en}))
        else $error("negative switches not one-hot");

    a_neg_pin_map: assert property ( // [RQ3]
        @(posedge clk) disable iff (!rst_n)
        neg_sel <= amux_pkg::CODE_PORT_LAST && !neg_hit
        |=> neg_pin_en == (16'h0001 << neg_sel[3:0]))
        else $error("negative pin map wrong");

    a_pos_pin_map: assert property ( // [RQ5]
        @(posedge clk) disable iff (!rst_n)
        pos_sel <= amux_pkg::CODE_PORT_LAST && !pos_hit
        |=> pos_pin_en == (16'h0001 << pos_sel[3:0]))
        else $error("positive pin map wrong");

    a_pos_temp_map: assert property ( // [RQ5]
        @(posedge clk) disable iff (!rst_n)
        pos_sel == amux_pkg::CODE_SPECIAL_A |=> pos_temp_en && !pos_vdd_en)
        else $error("temperature sensor not selected");

    a_pos_vdd_map: assert property ( // [RQ5]
        @(posedge clk) disable iff (!rst_n)
        pos_sel == amux_pkg::CODE_SPECIAL_B |=> pos_vdd_en && !pos_temp_en)
        else $error("supply not selected");

    a_neg_vref_map: assert property ( // [RQ3]
        @(posedge clk) disable iff (!rst_n)
        neg_sel == amux_pkg::CODE_SPECIAL_A
        |=> neg_vref_en && !neg_gnd_en && !single_ended)
        else $error("reference not selected");

    // Port 2 index is the low two code bits less two
    a_p2_map: assert property ( // [RQ4]
        @(posedge clk) disable iff (!rst_n)
        HAS_PORT2 && !pos_hit && pos_sel >= amux_pkg::CODE_P2_FIRST &&
        pos_sel <= amux_pkg::CODE_P2_LAST
        |=> pos_p2_en == (4'h1 << 2'(pos_sel[1:0] - 2'h2)))
        else $error("port 2 map wrong");

    a_p2_gate: assert property ( // [RQ4]
        @(posedge clk) disable iff (!rst_n)
        !HAS_PORT2 |-> pos_p2_en == 4'h0 && neg_p2_en == 4'h0)
        else $error("port 2 selected on small package");

    a_none_sel: assert property ( // [RQ1]
        @(posedge clk) disable iff (!rst_n)
        pos_sel > amux_pkg::CODE_P2_LAST
        |=> {pos_pin_en, pos_p2_en, pos_temp_en, pos_vdd_en} == 22'h0)
        else $error("unused positive code selected a source");

    a_neg_none_sel: assert property ( // [RQ2]
        @(posedge clk) disable iff (!rst_n)
        neg_sel > amux_pkg::CODE_P2_LAST
        |=> {neg_pin_en, neg_p2_en, neg_vref_en, neg_gnd_en} == 22'h0 &&
        !single_ended)
        else $error("unused negative code selected a source");

    // Sensor bias follows its enable with one register stage
    a_sensor_power: assert property ( // [RQ6]
        @(posedge clk) disable iff (!rst_n)
        temp_sensor_pwr == $past(temp_sensor_power_on))
        else $error("sensor power does not follow enable");
endmodule // adc_input_mux_select

//--- src/amux_pkg.sv
/*
 Constants for the converter input selection block: register offsets,
 field layout, reset values and selection codes.
 Assumes an 8-bit special-function register bus from the processor core.
*/
package amux_pkg;
    localparam logic [7:0] NEG_SEL_ADDR = 8'hBA;
    localparam logic [7:0] POS_SEL_ADDR = 8'hBB;
    localparam int SEL_W = 5;
    localparam logic [4:0] SEL_RESET = 5'h1F;
    localparam logic [4:0] CODE_PORT_LAST = 5'h0F;
    localparam logic [4:0] CODE_SPECIAL_A = 5'h10;
    localparam logic [4:0] CODE_SPECIAL_B = 5'h11;
    localparam logic [4:0] CODE_P2_FIRST = 5'h12;
    localparam logic [4:0] CODE_P2_LAST = 5'h15;
    localparam int PIN_SRC = 16;
    localparam int P2_SRC = 4;
endpackage

//--- test/core_model.sv
/* Processor core model: drives single-cycle register writes and reads.
   Assumes the bench clock; queues each expected read result. */
`timescale 1ns/1ps
module core_model (
    input wire logic clk, // System clock
    output logic [7:0] sfr_addr = 8'h00, // Register address
    output logic [7:0] sfr_wdata = 8'h00, // Write data
    output logic sfr_we = 1'b0, // Write strobe
    output logic sfr_re = 1'b0 // Read strobe
);
    logic [7:0] expect_q[$];
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_we <= 1'b1;
        @(posedge clk);
        sfr_we <= 1'b0;
        sfr_wdata <= ~d; // Released data must not linger
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        sfr_addr <= a;
        sfr_re <= 1'b1;
        expect_q.push_back(e);
        @(posedge clk);
        sfr_re <= 1'b0;
    endtask
endmodule // core_model

//--- test/testbench.sv
/* Self-checking bench for the converter input selection block.
   Assumes the core model drives the register strobes. */
`timescale 1ns/1ps
module testbench;
    logic clk, rst_n, tpo, rd_pend = 1'b0;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic sfr_we, sfr_re, pos_temp_en, pos_vdd_en, neg_vref_en, neg_gnd_en;
    logic single_ended, temp_sensor_pwr;
    logic [15:0] pos_pin_en, neg_pin_en;
    logic [3:0] pos_p2_en, neg_p2_en;
    logic [4:0] pc, nc;
    int n_mismatch = 0;
    int samples_checked = 0;
    core_model core (.clk(clk), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_we(sfr_we), .sfr_re(sfr_re));
    adc_input_mux_select #(.HAS_PORT2(1'b1)) uut (.clk(clk), .rst_n(rst_n),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_we(sfr_we),
        .sfr_re(sfr_re), .temp_sensor_power_on(tpo), .sfr_rdata(sfr_rdata),
        .pos_pin_en(pos_pin_en), .pos_p2_en(pos_p2_en),
        .pos_temp_en(pos_temp_en), .pos_vdd_en(pos_vdd_en),
        .neg_pin_en(neg_pin_en), .neg_p2_en(neg_p2_en),
        .neg_vref_en(neg_vref_en), .neg_gnd_en(neg_gnd_en),
        .single_ended(single_ended), .temp_sensor_pwr(temp_sensor_pwr));
    // Bit n = code n; codes above 0x15 select nothing
    function automatic logic [21:0] onehot(input logic [4:0] c);
        return (c < 5'h16) ? 22'h1 << c : 22'h0;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        if (rd_pend) check(sfr_rdata, core.expect_q.pop_front());
        rd_pend <= sfr_re;
    end
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #20000;
        n_mismatch++;
        close_out();
    end
    initial begin
        rst_n = 1'b0;
        tpo = 1'b0;
        void'($urandom(32'hC5E82F01));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        core.wr(8'hBC, 8'h00);
        core.rd(amux_pkg::NEG_SEL_ADDR, 8'h1F);
        core.rd(amux_pkg::POS_SEL_ADDR, 8'h1F);
        core.rd(8'h00, 8'h00);
        // Every code on both fields, then random pairs
        for (int i = 0; i < 40; i++) begin
            pc = (i < 32) ? 5'(i) : 5'($urandom);
            nc = (i < 32) ? 5'(31 - i) : 5'($urandom);
            tpo <= 1'($urandom);
            core.wr(amux_pkg::POS_SEL_ADDR, {3'($urandom), pc});
            core.wr(amux_pkg::NEG_SEL_ADDR, {3'($urandom), nc});
            repeat (2) @(posedge clk);
            #1;
            check({pos_p2_en, pos_vdd_en, pos_temp_en, pos_pin_en}, onehot(pc));
            check({neg_p2_en, neg_gnd_en, neg_vref_en, neg_pin_en}, onehot(nc));
            check(single_ended, nc == 5'h11);
            check(temp_sensor_pwr, tpo);
            core.rd(amux_pkg::POS_SEL_ADDR, {3'b000, pc});
            core.rd(amux_pkg::NEG_SEL_ADDR, {3'b000, nc});
        end
        repeat (3) @(posedge clk);
        close_out();
    end
endmodule // testbench
